// *** core/ddr2_cmd_defines.svh ***
// timing counts and field positions for the command and clock-enable control
`ifndef DDR2_CMD_DEFINES_SVH
`define DDR2_CMD_DEFINES_SVH
`define AUTO_PRE_BIT 10
`define DLL_RST_BIT 8
`define BURST_BEATS 4
`define BEAT_CNT_W 3
`define RELOCK_CYCLES 200
`define RELOCK_CNT_W 8
`define BANK_W 3
`define ADDR_W 14
`define NUM_BANKS 8
`endif

// *** core/ddr2_cmd_pkg.sv ***
// types for the command and clock-enable control
package ddr2_cmd_pkg;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_MODE_SET = 4'h1,
    CMD_REFRESH = 4'h2,
    CMD_PRECHARGE = 4'h3,
    CMD_ACTIVATE = 4'h4,
    CMD_WRITE = 4'h5,
    CMD_READ = 4'h6,
    CMD_ILLEGAL = 4'h7
  } cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_ACT_PDOWN = 3'b010,
    ST_PRE_PDOWN = 3'b011,
    ST_SELF_REFRESH = 3'b100
  } pstate_t;
endpackage : ddr2_cmd_pkg

// *** core/ddr2_cmd_ctrl.sv ***
// command decoder and clock-enable power-state control
`timescale 1ns/10ps
`include "ddr2_cmd_defines.svh"
module ddr2_cmd_ctrl (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [`BANK_W-1:0] i_bank,
  input wire logic [`ADDR_W-1:0] i_addr,
  output ddr2_cmd_pkg::cmd_t o_cmd,
  output ddr2_cmd_pkg::pstate_t o_pstate,
  output logic [`BANK_W-1:0] o_bank,
  output logic [`ADDR_W-1:0] o_addr,
  output logic o_auto_pre,
  output logic o_pre_all,
  output logic o_mode_set,
  output logic o_dll_reset,
  output logic o_burst_busy,
  output logic o_relock_busy,
  output logic o_ready,
  output logic o_illegal,
  output logic o_data_lost
);
  import ddr2_cmd_pkg::*;

  // no synchroniser: command pins are taken as synchronous to i_clock
  logic cke_prev_q;
  cmd_t cmd_q;
  pstate_t state_q;
  logic [`NUM_BANKS-1:0] open_q;
  logic [`BEAT_CNT_W-1:0] beat_q;
  logic [`RELOCK_CNT_W-1:0] relock_q;
  logic auto_pre_q;
  logic pre_all_q;
  logic mode_set_q;
  logic dll_reset_q;
  logic illegal_q;
  logic lost_q;
  logic [`BANK_W-1:0] bank_q;
  logic [`ADDR_W-1:0] addr_q;

  function automatic cmd_t decode(input logic cs_n, input logic ras_n,
                                  input logic cas_n, input logic we_n);
    if (cs_n) begin
      decode = CMD_NOP;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'b111: decode = CMD_NOP;
        3'b000: decode = CMD_MODE_SET;
        3'b001: decode = CMD_REFRESH;
        3'b010: decode = CMD_PRECHARGE;
        3'b011: decode = CMD_ACTIVATE;
        3'b100: decode = CMD_WRITE;
        3'b101: decode = CMD_READ;
        default: decode = CMD_ILLEGAL;
      endcase
    end
  endfunction : decode

  function automatic logic is_access(input cmd_t c);
    is_access = (c == CMD_READ) || (c == CMD_WRITE);
  endfunction : is_access

  cmd_t cmd_now;
  logic sleeping;
  logic enter_pd;
  logic enter_sr;
  logic wake;
  logic bad;
  always_comb begin
    cmd_now = decode(i_cs_n, i_ras_n, i_cas_n, i_we_n);
    sleeping = (state_q == ST_ACT_PDOWN) || (state_q == ST_PRE_PDOWN)
      || (state_q == ST_SELF_REFRESH);
    enter_pd = !sleeping && cke_prev_q && !i_cke && (cmd_now == CMD_NOP);
    enter_sr = !sleeping && cke_prev_q && !i_cke && (cmd_now == CMD_REFRESH)
      && (open_q == '0);
    wake = sleeping && !cke_prev_q && i_cke && (cmd_now == CMD_NOP);
    bad = 1'b0;
    if (!sleeping && cke_prev_q && !i_cke && !enter_pd && !enter_sr) begin
      bad = 1'b1;
    end
    if (sleeping && !cke_prev_q && i_cke && !wake) begin
      bad = 1'b1;
    end
    if (!sleeping && cke_prev_q && i_cke && cmd_now == CMD_ILLEGAL) begin
      bad = 1'b1;
    end
    if (!sleeping && !cke_prev_q && !i_cke) begin
      bad = 1'b1;
    end
  end

  logic act_ok;
  assign act_ok = !sleeping && cke_prev_q && i_cke && !bad;

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= i_cke;
    end
  end

  // power state; self-refresh exit needs no clocks before it, only the cke rise with a nop or deselect
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else if (enter_sr) begin
      state_q <= ST_SELF_REFRESH;
    end else if (enter_pd) begin
      state_q <= (open_q != '0) ? ST_ACT_PDOWN : ST_PRE_PDOWN;
    end else if (wake) begin
      state_q <= (state_q == ST_ACT_PDOWN) ? ST_ACTIVE : ST_IDLE;
    end else if (!sleeping) begin
      state_q <= (open_q != '0) ? ST_ACTIVE : ST_IDLE;
    end
  end

  // open banks follow activate and precharge
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      open_q <= '0;
    end else if (act_ok && cmd_now == CMD_ACTIVATE) begin
      open_q[i_bank] <= 1'b1;
    end else if (act_ok && cmd_now == CMD_PRECHARGE) begin
      if (i_addr[`AUTO_PRE_BIT]) begin
        open_q <= '0;
      end else begin
        open_q[i_bank] <= 1'b0;
      end
    end else if (act_ok && is_access(cmd_now) && i_addr[`AUTO_PRE_BIT]) begin
      open_q[i_bank] <= 1'b0;
    end
  end

  // burst counter: a nop does not touch it, nothing cuts it short
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      beat_q <= '0;
    end else if (beat_q != '0) begin
      beat_q <= beat_q - 1'b1;
    end else if (act_ok && is_access(cmd_now)) begin
      beat_q <= `BEAT_CNT_W'(`BURST_BEATS);
    end
  end

  // dll reset is an extended mode set to bank one with a8 set
  logic dll_rst_now;
  assign dll_rst_now = act_ok && cmd_now == CMD_MODE_SET
    && i_bank == `BANK_W'(1) && i_addr[`DLL_RST_BIT];

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      relock_q <= '0;
    end else if (dll_rst_now) begin
      relock_q <= `RELOCK_CNT_W'(`RELOCK_CYCLES);
    end else if (relock_q != '0) begin
      relock_q <= relock_q - 1'b1;
    end
  end

  // registered command and its fields
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      cmd_q <= CMD_NOP;
      bank_q <= '0;
      addr_q <= '0;
      auto_pre_q <= 1'b0;
      pre_all_q <= 1'b0;
      mode_set_q <= 1'b0;
      dll_reset_q <= 1'b0;
    end else begin
      cmd_q <= act_ok ? cmd_now : CMD_NOP;
      bank_q <= i_bank;
      addr_q <= i_addr;
      auto_pre_q <= act_ok && is_access(cmd_now) && i_addr[`AUTO_PRE_BIT];
      pre_all_q <= act_ok && cmd_now == CMD_PRECHARGE && i_addr[`AUTO_PRE_BIT];
      mode_set_q <= act_ok && cmd_now == CMD_MODE_SET;
      dll_reset_q <= dll_rst_now;
    end
  end

  // loss is sticky until reset, since only reinitialisation recovers
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      illegal_q <= 1'b0;
      lost_q <= 1'b0;
    end else begin
      illegal_q <= bad;
      if (cke_prev_q && !i_cke && (beat_q != '0 || !enter_pd && !enter_sr)) begin
        lost_q <= 1'b1;
      end
    end
  end

  assign o_cmd = cmd_q;
  assign o_pstate = state_q;
  assign o_bank = bank_q;
  assign o_addr = addr_q;
  assign o_auto_pre = auto_pre_q;
  assign o_pre_all = pre_all_q;
  assign o_mode_set = mode_set_q;
  assign o_dll_reset = dll_reset_q;
  assign o_burst_busy = (beat_q != '0);
  assign o_relock_busy = (relock_q != '0);
  assign o_ready = (relock_q == '0) && !sleeping && !lost_q;
  assign o_illegal = illegal_q;
  assign o_data_lost = lost_q;

  sequence s_dll_reset;
    dll_rst_now;
  endsequence
  sequence s_relock_hold;
    !o_ready [*8];
  endsequence
  sequence s_wake;
    wake;
  endsequence

  // all checks sample on the command clock; relock bound is the load plus one
  a_relock_not_ready: assert property (
    @(posedge i_clock) disable iff (!i_nrst) s_dll_reset |=> s_relock_hold)
    else $error("ready during relock");
  a_relock_ends: assert property (
    @(posedge i_clock) disable iff (!i_nrst) dll_rst_now |-> ##[1:201] !o_relock_busy)
    else $error("relock too long");
  a_dll_pulse: assert property (
    @(posedge i_clock) disable iff (!i_nrst) s_dll_reset |=> (o_dll_reset && o_relock_busy))
    else $error("dll reset not taken");
  a_deselect_is_nop: assert property (
    @(posedge i_clock) disable iff (!i_nrst) i_cs_n |=> o_cmd == CMD_NOP)
    else $error("deselect not nop");
  a_nop_decode: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (!i_cs_n && i_ras_n && i_cas_n && i_we_n) |=> o_cmd == CMD_NOP)
    else $error("nop misdecoded");
  a_burst_complete: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(o_burst_busy) |-> o_burst_busy [*4] ##1 !o_burst_busy)
    else $error("burst cut short");
  a_nop_keeps_burst: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (beat_q > `BEAT_CNT_W'(1) && cmd_now == CMD_NOP) |=> o_burst_busy)
    else $error("nop cut burst");
  a_pre_all: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (act_ok && cmd_now == CMD_PRECHARGE && i_addr[`AUTO_PRE_BIT]) |=> open_q == '0)
    else $error("precharge all missed");
  a_single_pre: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (act_ok && cmd_now == CMD_PRECHARGE && !i_addr[`AUTO_PRE_BIT]) |=> !open_q[$past(i_bank)])
    else $error("single bank precharge missed");
  a_auto_pre_flag: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (act_ok && is_access(cmd_now) && i_addr[`AUTO_PRE_BIT]) |=> o_auto_pre)
    else $error("auto precharge missed");
  a_mode_bank: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (act_ok && cmd_now == CMD_MODE_SET) |=> (o_mode_set && o_bank == $past(i_bank)))
    else $error("mode set bank lost");
  a_sr_entry: assert property (
    @(posedge i_clock) disable iff (!i_nrst) enter_sr |=> o_pstate == ST_SELF_REFRESH)
    else $error("no self refresh");
  a_pd_kind: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (enter_pd && open_q != '0) |=> o_pstate == ST_ACT_PDOWN)
    else $error("wrong power down");
  a_wake_kind: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    s_wake |=> o_pstate inside {ST_ACTIVE, ST_IDLE})
    else $error("wake to wrong state");
  a_sleep_held: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (sleeping && !cke_prev_q && !i_cke) |=> $stable(o_pstate))
    else $error("sleep not held");
  a_asleep_quiet: assert property (
    @(posedge i_clock) disable iff (!i_nrst) sleeping |=> o_cmd == CMD_NOP)
    else $error("command acted on while asleep");
  a_illegal_flag: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (act_ok == 1'b0 && !sleeping && cke_prev_q && i_cke) |=> o_illegal)
    else $error("illegal not flagged");
  a_lost_on_drop: assert property (
    @(posedge i_clock) disable iff (!i_nrst)
    (cke_prev_q && !i_cke && !enter_pd && !enter_sr) |=> o_data_lost)
    else $error("cke drop not marked");
endmodule : ddr2_cmd_ctrl

// *** test/ddr2_ctrl_model.sv ***
// controller-side driver of command, address and clock-enable pins
`timescale 1ns/10ps
`include "ddr2_cmd_defines.svh"
module ddr2_ctrl_model (
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [`BANK_W-1:0] o_bank,
  output logic [`ADDR_W-1:0] o_addr
);
  // every pin stays at a defined level, power-down too; no termination pin here
  initial begin
    o_cke = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'h7;
    o_bank = 3'h0;
    o_addr = 14'h0000;
  end
  // caller steps 1 ns after an edge; pins then hold a full cycle
  task automatic issue(input logic [3:0] c, input logic k, input logic [2:0] b,
                       input logic [13:0] a);
    o_cke = k;
    o_cs_n = c[3];
    if (c[3]) begin
      // deselected strobes are junk, never the strobes of the step before
      {o_ras_n, o_cas_n, o_we_n} = ~{o_ras_n, o_cas_n, o_we_n};
    end else begin
      {o_ras_n, o_cas_n, o_we_n} = c[2:0];
    end
    o_bank = b;
    o_addr = a;
  endtask : issue
endmodule : ddr2_ctrl_model

// *** test/ddr2_command_and_cke_state_control_tb.sv ***
// self-checking bench for the command decoder and power-state control
`timescale 1ns/10ps
module ddr2_command_and_cke_state_control_tb;
  import ddr2_cmd_pkg::*;
  typedef struct packed {
    logic [3:0] c;
    logic [2:0] b;
    logic [13:0] a;
    cmd_t cmd;
    logic ap;
    logic pa;
    logic ms;
  } row_t;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] bank;
  logic [13:0] addr;
  cmd_t o_cmd;
  pstate_t o_pstate;
  logic [2:0] o_bank;
  logic [13:0] o_addr;
  logic o_auto_pre, o_pre_all, o_mode_set, o_dll_reset, o_burst_busy;
  logic o_relock_busy, o_ready, o_illegal, o_data_lost;
  int miscompares = 0;
  int n_tests = 0;
  int n;
  row_t rows [10] = '{
    '{4'h7, 3'h0, 14'h0000, CMD_NOP, 1'b0, 1'b0, 1'b0},
    '{4'h8, 3'h5, 14'h1234, CMD_NOP, 1'b0, 1'b0, 1'b0},
    '{4'h0, 3'h2, 14'h0005, CMD_MODE_SET, 1'b0, 1'b0, 1'b1},
    '{4'h1, 3'h0, 14'h0000, CMD_REFRESH, 1'b0, 1'b0, 1'b0},
    '{4'h3, 3'h3, 14'h0abc, CMD_ACTIVATE, 1'b0, 1'b0, 1'b0},
    '{4'h4, 3'h3, 14'h0408, CMD_WRITE, 1'b1, 1'b0, 1'b0},
    '{4'h5, 3'h3, 14'h0010, CMD_READ, 1'b0, 1'b0, 1'b0},
    '{4'h2, 3'h3, 14'h0000, CMD_PRECHARGE, 1'b0, 1'b0, 1'b0},
    '{4'h2, 3'h1, 14'h0400, CMD_PRECHARGE, 1'b0, 1'b1, 1'b0},
    '{4'h6, 3'h0, 14'h0000, CMD_NOP, 1'b0, 1'b0, 1'b0}};
  always #25 i_clock = ~i_clock;
  ddr2_ctrl_model m (.o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n),
    .o_we_n(we_n), .o_bank(bank), .o_addr(addr));
  ddr2_cmd_ctrl uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n), .i_bank(bank), .i_addr(addr),
    .o_cmd(o_cmd), .o_pstate(o_pstate), .o_bank(o_bank), .o_addr(o_addr),
    .o_auto_pre(o_auto_pre), .o_pre_all(o_pre_all), .o_mode_set(o_mode_set),
    .o_dll_reset(o_dll_reset), .o_burst_busy(o_burst_busy), .o_relock_busy(o_relock_busy),
    .o_ready(o_ready), .o_illegal(o_illegal), .o_data_lost(o_data_lost));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // drive 1 ns after an edge, return 1 ns after the edge that takes it
  task automatic step(input logic [3:0] c, input logic k, input logic [2:0] b,
                      input logic [13:0] a);
    m.issue(c, k, b, a);
    @(posedge i_clock);
    #1;
  endtask : step
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    #(2000 * 50);
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    check(32'(o_cmd), 32'(CMD_NOP));
    check(32'(o_pstate), 32'(ST_IDLE));
    repeat (2) step(4'h7, 1'b1, 3'h0, 14'h0000);
    foreach (rows[i]) begin
      step(rows[i].c, 1'b1, rows[i].b, rows[i].a);
      check(32'(o_cmd), 32'(rows[i].cmd));
      check({o_auto_pre, o_pre_all, o_mode_set}, {rows[i].ap, rows[i].pa, rows[i].ms});
      check(o_illegal, rows[i].c == 4'h6);
      if (rows[i].cmd !== CMD_NOP) check({o_bank, o_addr}, {rows[i].b, rows[i].a});
    end
    $display("decode rows done");
    repeat (6) step(4'h7, 1'b1, 3'h0, 14'h0000);
    step(4'h5, 1'b1, 3'h2, 14'h0004);
    for (int i = 0; i < 4; i++) begin
      check(o_burst_busy, 1'b1);
      step(4'h7, 1'b1, 3'h0, 14'h0000);
    end
    check(o_burst_busy, 1'b0);
    $display("burst done");
    step(4'h7, 1'b0, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_PRE_PDOWN));
    repeat (2) step(4'h8, 1'b0, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_PRE_PDOWN));
    step(4'h7, 1'b1, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_IDLE));
    repeat (2) step(4'h7, 1'b1, 3'h0, 14'h0000);
    step(4'h3, 1'b1, 3'h4, 14'h0001);
    step(4'h8, 1'b0, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_ACT_PDOWN));
    repeat (2) step(4'h7, 1'b0, 3'h0, 14'h0000);
    step(4'h8, 1'b1, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_ACTIVE));
    repeat (2) step(4'h7, 1'b1, 3'h0, 14'h0000);
    step(4'h2, 1'b1, 3'h0, 14'h0400);
    repeat (2) step(4'h7, 1'b1, 3'h0, 14'h0000);
    step(4'h1, 1'b0, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_SELF_REFRESH));
    repeat (2) step(4'h5, 1'b0, 3'h0, 14'h0000); // clock steady while asleep
    check(32'(o_cmd), 32'(CMD_NOP));
    step(4'h7, 1'b1, 3'h0, 14'h0000);
    check(32'(o_pstate), 32'(ST_IDLE));
    repeat (3) step(4'h7, 1'b1, 3'h0, 14'h0000);
    $display("power states done");
    step(4'h0, 1'b1, 3'h1, 14'h0100);
    check({o_dll_reset, o_ready}, 2'b10);
    n = 0;
    while (o_relock_busy === 1'b1 && n < 300) begin
      n++;
      step(4'h7, 1'b1, 3'h0, 14'h0000);
    end
    check(n, 200);
    check(o_ready, 1'b1);
    $display("relock done");
    step(4'h5, 1'b0, 3'h0, 14'h0000);
    check({o_illegal, o_data_lost}, 2'b11);
    check(32'(o_cmd), 32'(CMD_NOP));
    repeat (3) step(4'h7, 1'b0, 3'h0, 14'h0000);
    check({o_illegal, o_data_lost, o_ready}, 3'b110);
    i_nrst = 1'b0;
    repeat (2) step(4'h7, 1'b1, 3'h0, 14'h0000);
    i_nrst = 1'b1;
    check({o_data_lost, o_relock_busy, o_burst_busy}, 3'b000);
    check(32'(o_pstate), 32'(ST_IDLE));
    step(4'h7, 1'b1, 3'h0, 14'h0000);
    check({o_illegal, o_cmd == CMD_NOP}, 2'b01);
    $display("lost and reset done");
    report_and_stop();
  end
endmodule : ddr2_command_and_cke_state_control_tb
